// file: common/psq_pkg.sv
// shared constants and types for the multi-supply power sequencer
// assumes a 40 MHz core clock; times are held in ns and converted to cycles
package psq_pkg;

  // core clock period
  localparam int CLK_NS = 25;

  // timing-cycle lengths per nF of timer capacitance, scaled from per uF
  localparam int START_NS_PER_NF = 23300;
  localparam int GOOD_NS_PER_NF = 233000;
  localparam int COOL_NS_PER_NF = 1170000;
  localparam int DEF_CAP_NF = 100;

  // qualification, deglitch and good-input filter times
  localparam int QUALIFY_NS = 100000000;
  localparam int PB_GLITCH_NS = 15000;
  localparam int GOOD_LOW_NS = 20000;
  localparam int PB_GLITCH_CYC = (PB_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int GOOD_LOW_CYC = (GOOD_LOW_NS + CLK_NS - 1) / CLK_NS;

  // timer discharge time from upper threshold down past lower threshold
  localparam int FALL_CYC = 4;

  // supply bit order: 12V, 5V, 3.3V, -12V
  localparam logic [3:0] ALL_ON = 4'hf;
  localparam int SUP_NEG12 = 3;

  // control bit defaults after power-on reset
  localparam logic SEQ_DEFAULT = 1'b0;
  localparam logic GOOD_DIS_DEFAULT = 1'b0;

  // three-state configuration pin
  localparam logic [1:0] CFG_LOW = 2'h0;
  localparam logic [1:0] CFG_OPEN = 2'h1;
  localparam logic [1:0] CFG_HIGH = 2'h2;

  // timer charge current selection
  typedef enum logic [1:0] {TCUR_IDLE, TCUR_START, TCUR_GOOD, TCUR_COOL} psq_tcur_e;

  // sequencer states
  typedef enum logic [2:0] {ST_OFF, ST_START, ST_GOOD, ST_NORMAL, ST_COOL} psq_state_e;

endpackage

// file: common/psq_tmr_if.sv
// timing-cycle request and completion between sequencer and timer
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface psq_tmr_if;
  logic start;
  logic [31:0] length;
  logic done;
  logic busy;
  modport ctl(output start, length, input done, busy);
  modport tmr(input start, length, output done, busy);
endinterface
`default_nettype wire

// file: design/psq_sync.sv
// two-flop synchroniser for a vector of pin-level inputs
// assumes inputs are levels that change slowly against the clock
`timescale 1ns/1ps
`default_nettype none
module psq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins in, synchronised copies out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } psq_sync_s;

  psq_sync_s q;
  psq_sync_s d;

  // first stage feeds only the second stage
  always_comb begin
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;

endmodule
`default_nettype wire

// file: design/psq_timer.sv
// shared timing-cycle counter: ramp to length, then discharge phase
// assumes start is a one-cycle pulse and length stays put while busy
`timescale 1ns/1ps
`default_nettype none
module psq_timer (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request and completion
  psq_tmr_if.tmr tif
);

  localparam int FALL_N = psq_pkg::FALL_CYC;

  typedef struct packed {
    logic [31:0] count;
    logic ramp;
    logic fall;
    logic done;
  } psq_tmr_s;

  psq_tmr_s q;
  psq_tmr_s d;

  // a new start restarts the cycle even if one is running
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (tif.start) begin
      d.count = '0;
      d.ramp = 1'b1;
      d.fall = 1'b0;
    end else if (q.ramp) begin
      if (q.count + 32'h1 >= tif.length) begin
        d.ramp = 1'b0;
        d.fall = 1'b1;
        d.count = '0;
      end else begin
        d.count = q.count + 32'h1;
      end
    end else if (q.fall) begin
      if (q.count + 32'h1 >= 32'(FALL_N)) begin
        d.fall = 1'b0;
        d.done = 1'b1;
      end else begin
        d.count = q.count + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.done = q.done;
  assign tif.busy = q.ramp | q.fall;

  property p_fall_end;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.fall) && !tif.start |-> ##FALL_N q.done;
  endproperty
  a_fall_end: assert property (p_fall_end) else $error("timer end not after discharge");

endmodule
`default_nettype wire

// file: design/psq_sequencer.sv
// multi-supply power sequencer: turn-on, timing cycles, faults, power-ok
// assumes comparator flags and pins are asynchronous, host control is on clk
//
// Overview of operation
// - host reset low forces board reset low
// - otherwise board reset is inverse of power-ok
// - all supplies on starts timeout, then samples good
// - good input low too long trips, unless disabled
// - cycle lengths scale with one timer capacitance
// - cycle ramps to top, resets, ends below bottom
// - start-up ending in current limit shuts down
// - clean start-up arms breaker, resets soft-start
// - together by default, else 12V,5V,3.3V,-12V
// - sequenced: one ramp end starts the next
// - each supply has its own on bit
// - fault, on low, board removed: all off together
// - after last start-up, power-ok if all good
// - good low records fault, cools; high means normal
// - normal-mode undervoltage or overcurrent shuts all off
// - power bad drops power-ok, keeps switches on
// - -12V lockout blocks turn-on unless configured off
// - config pin disables -12V checks, retargets 5V
// - on rise turns on, fall turns off, clears faults
// - turn-on needs 100 ms of clean conditions
// - power-bad deglitched 15 us before power-ok drops
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer #(
  parameter int TIMER_CAP_NF = psq_pkg::DEF_CAP_NF,
  parameter int START_CYCLES = psq_pkg::START_NS_PER_NF * TIMER_CAP_NF / psq_pkg::CLK_NS,
  parameter int GOOD_CYCLES = psq_pkg::GOOD_NS_PER_NF * TIMER_CAP_NF / psq_pkg::CLK_NS,
  parameter int COOL_CYCLES = psq_pkg::COOL_NS_PER_NF * TIMER_CAP_NF / psq_pkg::CLK_NS,
  parameter int QUALIFY_CYCLES = (psq_pkg::QUALIFY_NS + psq_pkg::CLK_NS - 1) / psq_pkg::CLK_NS
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset_n,
  // backplane and load pins
  input wire logic on_in,
  input wire logic board_present_n,
  input wire logic host_reset_n,
  input wire logic downstream_good_in,
  input wire logic [1:0] cfg_mode,
  // comparator flags, bit order 12V, 5V, 3.3V, -12V
  input wire logic [3:0] supply_uv,
  input wire logic [3:0] power_bad,
  input wire logic [3:0] current_limit,
  input wire logic [3:0] breaker_comparator,
  // host control bits
  input wire logic ctrl_write,
  input wire logic [3:0] ctrl_on,
  input wire logic ctrl_sequence,
  input wire logic ctrl_good_disable,
  // supply switch control
  output logic [3:0] gate_on,
  output logic [3:0] breaker_armed,
  output logic soft_start_charge,
  output logic [1:0] timer_charge_current,
  output logic vee_checks_off,
  output logic five_at_three_levels,
  // board status pins, drive enables active low
  output logic power_ok_n,
  output logic power_ok_drive_n,
  output logic board_reset_n,
  output logic board_reset_drive_n,
  // status
  output logic [3:0] on_bits,
  output logic fault_overcurrent,
  output logic fault_undervoltage,
  output logic fault_good
);

  localparam logic [31:0] QUAL_LAST = 32'(QUALIFY_CYCLES - 1);
  localparam logic [15:0] PB_LAST = 16'(psq_pkg::PB_GLITCH_CYC - 1);
  localparam logic [15:0] LOW_LAST = 16'(psq_pkg::GOOD_LOW_CYC - 1);

  typedef struct packed {
    psq_pkg::psq_state_e st;
    logic [3:0] on_bits;
    logic [3:0] gate;
    logic [3:0] ramp;
    logic [3:0] armed;
    logic seq;
    logic good_dis;
    logic f_oc;
    logic f_uv;
    logic f_good;
    logic prev_on;
    logic prev_bp;
    logic [31:0] qual_cnt;
    logic qual_ok;
    logic [15:0] pb_cnt;
    logic pb_bad;
    logic [15:0] low_cnt;
    logic power_ok_n_en;
    logic tmr_start;
    logic [31:0] tmr_len;
    psq_pkg::psq_tcur_e tsel;
    logic ss_run;
    logic vee_off;
    logic five33;
    logic pok_n;
    logic rst_out;
  } psq_main_s;

  psq_main_s q;
  psq_main_s d;

  // synchronised pins and flags
  logic [21:0] pin_s;
  logic on_s, bp_s, host_s, good_s;
  logic [1:0] cfg_s;
  logic [3:0] uv_s, pb_s, cl_s, bc_s;
  logic on_rise, on_fall, bp_fall;
  logic lockout, qual_cond, start_ok, good_low;
  logic [3:0] pb_mask;
  logic [3:0] pend;

  psq_tmr_if tif();

  psq_sync #(.W(22)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({on_in, board_present_n, host_reset_n, downstream_good_in, cfg_mode,
               supply_uv, power_bad, current_limit, breaker_comparator}),
    .sync_out(pin_s)
  );

  psq_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tif(tif)
  );

  assign {on_s, bp_s, host_s, good_s, cfg_s, uv_s, pb_s, cl_s, bc_s} = pin_s;

  // edges and qualification terms; -12V checks follow the config pin
  assign on_rise = on_s & ~q.prev_on;
  assign on_fall = ~on_s & q.prev_on;
  assign bp_fall = ~bp_s & q.prev_bp;
  assign lockout = |(uv_s & {~q.vee_off, 3'h7});
  assign pb_mask = pb_s & {~q.vee_off, 3'h7};
  assign qual_cond = ~lockout & ~(q.f_oc | q.f_uv | q.f_good) & ~bp_s;
  assign start_ok = q.qual_ok & qual_cond;
  assign good_low = (q.low_cnt >= LOW_LAST) & ~good_s;

  assign tif.start = q.tmr_start;
  assign tif.length = q.tmr_len;

  // all switches off together; a fault then cools down, otherwise idle
  function automatic psq_main_s shut_all(input psq_main_s s, input logic cool);
    s.gate = '0;
    s.ramp = '0;
    s.armed = '0;
    s.on_bits = '0;
    s.power_ok_n_en = 1'b0;
    s.tmr_start = cool;
    s.tmr_len = 32'(COOL_CYCLES);
    s.tsel = cool ? psq_pkg::TCUR_COOL : psq_pkg::TCUR_IDLE;
    s.st = cool ? psq_pkg::ST_COOL : psq_pkg::ST_OFF;
    return s;
  endfunction

  // start a ramp: lowest pending supply when sequenced, else all pending
  function automatic psq_main_s begin_ramp(input psq_main_s s, input logic [3:0] want);
    s.ramp = s.seq ? (want & (~want + 4'h1)) : want;
    s.gate = s.gate | s.ramp;
    s.power_ok_n_en = 1'b0;
    s.tmr_start = 1'b1;
    s.tmr_len = 32'(START_CYCLES);
    s.tsel = psq_pkg::TCUR_START;
    s.st = psq_pkg::ST_START;
    return s;
  endfunction

  // next-state logic
  always_comb begin
    d = q;
    d.tmr_start = 1'b0;
    pend = 4'h0;
    // host writes to the control bits
    if (ctrl_write) begin
      d.on_bits = ctrl_on;
      d.seq = ctrl_sequence;
      d.good_dis = ctrl_good_disable;
    end
    d.vee_off = (cfg_s != psq_pkg::CFG_LOW);
    d.five33 = (cfg_s == psq_pkg::CFG_HIGH);
    d.prev_on = on_s;
    d.prev_bp = bp_s;
    // pin edges; clears come first so a fault in the same cycle wins
    if (on_rise) begin
      d.on_bits = psq_pkg::ALL_ON;
    end
    if (on_fall || bp_fall) begin
      d.f_oc = 1'b0;
      d.f_uv = 1'b0;
      d.f_good = 1'b0;
    end
    if (bp_fall) begin
      d.on_bits = {4{on_s}};
    end
    // 100 ms of clean conditions before any turn-on
    if (!qual_cond) begin
      d.qual_cnt = '0;
      d.qual_ok = 1'b0;
    end else if (q.qual_cnt >= QUAL_LAST) begin
      d.qual_ok = 1'b1;
    end else begin
      d.qual_cnt = q.qual_cnt + 32'h1;
    end
    // power-bad deglitch
    if (|pb_mask) begin
      if (q.pb_cnt >= PB_LAST) begin
        d.pb_bad = 1'b1;
      end else begin
        d.pb_cnt = q.pb_cnt + 16'h1;
      end
    end else begin
      d.pb_cnt = '0;
      d.pb_bad = 1'b0;
    end
    // good-input low filter, saturating
    if (good_s) begin
      d.low_cnt = '0;
    end else if (q.low_cnt < LOW_LAST) begin
      d.low_cnt = q.low_cnt + 16'h1;
    end
    // clearing an on bit drops only that supply
    d.gate = q.gate & d.on_bits;
    d.ramp = q.ramp & d.on_bits;
    d.armed = q.armed & d.gate;
    if (tif.done) begin
      d.tsel = psq_pkg::TCUR_IDLE;
    end
    pend = d.on_bits & ~d.gate;
    case (q.st)
      psq_pkg::ST_OFF, psq_pkg::ST_NORMAL: begin
        if (|pend && start_ok) begin
          d = begin_ramp(d, pend);
        end
      end
      psq_pkg::ST_START: begin
        if (tif.done) begin
          if (|(q.ramp & cl_s)) begin
            d = shut_all(d, 1'b1);
            d.f_oc = 1'b1;
          end else begin
            d.armed = d.armed | d.ramp;
            d.ramp = '0;
            pend = d.on_bits & ~d.gate;
            if (|pend && d.seq && start_ok) begin
              d = begin_ramp(d, pend);
            end else if (d.gate == psq_pkg::ALL_ON) begin
              d.power_ok_n_en = ~|pb_mask;
              d.tmr_start = 1'b1;
              d.tmr_len = 32'(GOOD_CYCLES);
              d.tsel = psq_pkg::TCUR_GOOD;
              d.st = psq_pkg::ST_GOOD;
            end else begin
              d.st = psq_pkg::ST_NORMAL;
            end
          end
        end
      end
      psq_pkg::ST_GOOD: begin
        if (tif.done) begin
          if (!good_s) begin
            d = shut_all(d, 1'b1);
            d.f_good = 1'b1;
          end else begin
            d.st = psq_pkg::ST_NORMAL;
          end
        end
      end
      psq_pkg::ST_COOL: begin
        if (tif.done) begin
          d.st = psq_pkg::ST_OFF;
        end
      end
      default: begin
        d.st = psq_pkg::ST_OFF;
      end
    endcase
    // faults while any supply is up
    if (q.st == psq_pkg::ST_START || q.st == psq_pkg::ST_GOOD || q.st == psq_pkg::ST_NORMAL) begin
      if (lockout) begin
        d = shut_all(d, 1'b1);
        d.f_uv = 1'b1;
      end
      if (|(bc_s & q.armed)) begin
        d = shut_all(d, 1'b1);
        d.f_oc = 1'b1;
      end
      if (q.st == psq_pkg::ST_NORMAL && !q.good_dis && good_low) begin
        d = shut_all(d, 1'b1);
        d.f_good = 1'b1;
      end
    end
    // removal or on low overrides everything, no cool-down
    if (bp_s || on_fall) begin
      d = shut_all(d, 1'b0);
    end
    // power-ok never touches the switches
    d.pok_n = ~(d.power_ok_n_en & (d.gate == psq_pkg::ALL_ON) & ~d.pb_bad);
    d.rst_out = host_s & ~d.pok_n;
    d.ss_run = (d.st == psq_pkg::ST_START);
  end

  // state register; defaults restored by power-on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.seq <= psq_pkg::SEQ_DEFAULT;
      q.good_dis <= psq_pkg::GOOD_DIS_DEFAULT;
      q.pok_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign gate_on = q.gate;
  assign breaker_armed = q.armed;
  assign soft_start_charge = q.ss_run;
  assign timer_charge_current = q.tsel;
  assign vee_checks_off = q.vee_off;
  assign five_at_three_levels = q.five33;
  assign power_ok_n = q.pok_n;
  assign power_ok_drive_n = q.pok_n;
  assign board_reset_n = q.rst_out;
  assign board_reset_drive_n = q.rst_out;
  assign on_bits = q.on_bits;
  assign fault_overcurrent = q.f_oc;
  assign fault_undervoltage = q.f_uv;
  assign fault_good = q.f_good;

  property p_host_reset;
    @(posedge clk) disable iff (!reset_n)
    !host_s |=> !board_reset_n;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("board reset not low");

  property p_follow_ok;
    @(posedge clk) disable iff (!reset_n)
    host_s |=> (board_reset_n == !power_ok_n);
  endproperty
  a_follow_ok: assert property (p_follow_ok) else $error("board reset not inverse of ok");

  property p_good_sample;
    @(posedge clk) disable iff (!reset_n)
    q.st == psq_pkg::ST_GOOD && tif.done && !good_s |=> fault_good && gate_on == 4'h0;
  endproperty
  a_good_sample: assert property (p_good_sample) else $error("good sample ignored");

  property p_good_low;
    @(posedge clk) disable iff (!reset_n)
    q.st == psq_pkg::ST_NORMAL && !q.good_dis && good_low |=> fault_good && gate_on == 4'h0;
  endproperty
  a_good_low: assert property (p_good_low) else $error("good low not acted on");

  property p_start_limit;
    @(posedge clk) disable iff (!reset_n)
    q.st == psq_pkg::ST_START && tif.done && |(q.ramp & cl_s) |=> fault_overcurrent && gate_on == 4'h0;
  endproperty
  a_start_limit: assert property (p_start_limit) else $error("limit at start-up end missed");

  property p_seq_one;
    @(posedge clk) disable iff (!reset_n)
    q.tmr_start && q.st == psq_pkg::ST_START && q.seq |-> $onehot(q.ramp);
  endproperty
  a_seq_one: assert property (p_seq_one) else $error("sequenced ramp not single");

  property p_removed;
    @(posedge clk) disable iff (!reset_n)
    bp_s |=> gate_on == 4'h0;
  endproperty
  a_removed: assert property (p_removed) else $error("switches on while removed");

  property p_lockout;
    @(posedge clk) disable iff (!reset_n)
    lockout |=> (gate_on & ~$past(gate_on)) == 4'h0;
  endproperty
  a_lockout: assert property (p_lockout) else $error("turn-on during lockout");

  property p_pb_drop;
    @(posedge clk) disable iff (!reset_n)
    q.pb_bad |-> power_ok_n && !board_reset_n;
  endproperty
  a_pb_drop: assert property (p_pb_drop) else $error("power bad kept ok asserted");

  property p_pb_glitch;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.pb_bad) |-> $past(q.pb_cnt) == PB_LAST;
  endproperty
  a_pb_glitch: assert property (p_pb_glitch) else $error("power bad deglitch wrong");

  property p_qualify;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.qual_ok) |-> q.qual_cnt == QUAL_LAST;
  endproperty
  a_qualify: assert property (p_qualify) else $error("qualify time wrong");

endmodule
`default_nettype wire

// file: testbench/psq_slot_model.sv
// partner model: backplane slot, host reset source and downstream supply monitor
// assumes the bench steers it through seated, hold_rst and fail on the falling edge
`timescale 1ns/1ps
`default_nettype none
module psq_slot_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench steering
  input wire logic seated,
  input wire logic hold_rst,
  input wire logic fail,
  // board side
  input wire logic [3:0] gate_on,
  // pins toward the sequencer
  output logic board_present_n,
  output logic host_reset_n,
  output logic downstream_good_in
);
  logic [2:0] up_cnt;
  // slot grounds the present pin only while the card is seated
  assign board_present_n = ~seated;
  assign host_reset_n = ~hold_rst;
  // monitor needs a few cycles of all rails on; it never claims good with a rail off
  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 3'h0;
    end else if (gate_on != 4'hf) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h4) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  assign downstream_good_in = (up_cnt == 3'h4) && !fail;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the power sequencer with short timing cycles
// assumes the slot model in psq_slot_model.sv; all inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int ST_C = 20;
  localparam int GD_C = 40;
  localparam int CL_C = 60;
  localparam int QU_C = 30;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic on_in = 1'b0;
  logic [1:0] cfg_mode = 2'h0;
  logic [3:0] supply_uv = 4'h0;
  logic [3:0] power_bad = 4'h0;
  logic [3:0] current_limit = 4'h0;
  logic [3:0] breaker_comparator = 4'h0;
  logic ctrl_write = 1'b0;
  logic [3:0] ctrl_on = 4'h0;
  logic ctrl_sequence = 1'b0;
  logic ctrl_good_disable = 1'b0;
  logic seated = 1'b1;
  logic hold_rst = 1'b0;
  logic fail = 1'b0;
  logic board_present_n, host_reset_n, downstream_good_in;
  logic [3:0] gate_on, breaker_armed, on_bits;
  logic [1:0] tcur;
  logic soft_start_charge, vee_checks_off, five_at_three_levels, power_ok_n, board_reset_n;
  logic fault_overcurrent, fault_undervoltage, fault_good;
  logic pok_drv_n, rst_drv_n;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  psq_sequencer #(.START_CYCLES(ST_C), .GOOD_CYCLES(GD_C), .COOL_CYCLES(CL_C),
    .QUALIFY_CYCLES(QU_C)) dut (
    .clk(clk), .reset_n(reset_n), .on_in(on_in), .board_present_n(board_present_n),
    .host_reset_n(host_reset_n), .downstream_good_in(downstream_good_in),
    .cfg_mode(cfg_mode), .supply_uv(supply_uv), .power_bad(power_bad),
    .current_limit(current_limit), .breaker_comparator(breaker_comparator),
    .ctrl_write(ctrl_write), .ctrl_on(ctrl_on), .ctrl_sequence(ctrl_sequence),
    .ctrl_good_disable(ctrl_good_disable), .gate_on(gate_on), .breaker_armed(breaker_armed),
    .soft_start_charge(soft_start_charge), .timer_charge_current(tcur),
    .vee_checks_off(vee_checks_off), .five_at_three_levels(five_at_three_levels),
    .power_ok_n(power_ok_n), .power_ok_drive_n(pok_drv_n), .board_reset_n(board_reset_n),
    .board_reset_drive_n(rst_drv_n), .on_bits(on_bits), .fault_overcurrent(fault_overcurrent),
    .fault_undervoltage(fault_undervoltage), .fault_good(fault_good));

  psq_slot_model slot (
    .clk(clk), .reset_n(reset_n), .seated(seated), .hold_rst(hold_rst), .fail(fail),
    .gate_on(gate_on), .board_present_n(board_present_n), .host_reset_n(host_reset_n),
    .downstream_good_in(downstream_good_in));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the scenarios need
  always @(negedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // bounded waits; k reports how many cycles passed
  task automatic wait_tcur(input logic [1:0] v, output int k);
    k = 0;
    while (tcur !== v && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic wait_gate(input logic [3:0] v, output int k);
    k = 0;
    while (gate_on !== v && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask

  // full power-on reset with chosen pin levels, defaults checked while held
  task automatic restart(input logic on, input logic [1:0] cfg, input logic [3:0] uv);
    reset_n = 1'b0;
    on_in = on;
    cfg_mode = cfg;
    supply_uv = uv;
    power_bad = 4'h0;
    current_limit = 4'h0;
    breaker_comparator = 4'h0;
    seated = 1'b1;
    hold_rst = 1'b0;
    fail = 1'b0;
    cyc(16);
    chk("reset gates", 4'h0, gate_on);
    chk("reset on bits", 4'h0, on_bits);
    chk1("reset power ok", 1'b1, power_ok_n);
    chk1("reset faults", 1'b0, fault_overcurrent | fault_undervoltage | fault_good);
    reset_n = 1'b1;
  endtask

  task automatic write_ctrl(input logic [3:0] on, input logic seq, input logic dis);
    ctrl_on = on;
    ctrl_sequence = seq;
    ctrl_good_disable = dis;
    ctrl_write = 1'b1;
    cyc(1);
    ctrl_write = 1'b0;
  endtask

  task automatic bring_up();
    restart(1'b1, psq_pkg::CFG_LOW, 4'h0);
    wait_tcur(psq_pkg::TCUR_GOOD, n);
    wait_tcur(psq_pkg::TCUR_IDLE, n);
  endtask

  // simultaneous start, timing lengths, power-ok and board reset handling
  task automatic t_simul();
    restart(1'b1, psq_pkg::CFG_LOW, 4'h0);
    cyc(8);
    chk("on bits", 4'hf, on_bits);
    cyc(12);
    chk("gates before qualify", 4'h0, gate_on);
    wait_gate(4'hf, n);
    chk("gates together", 4'hf, gate_on);
    chk1("soft start", 1'b1, soft_start_charge);
    chk("start current", {2'h0, psq_pkg::TCUR_START}, {2'h0, tcur});
    wait_tcur(psq_pkg::TCUR_GOOD, n);
    chk1("start length", 1'b1, n >= ST_C + 3 && n <= ST_C + 7);
    chk("armed", 4'hf, breaker_armed);
    chk1("soft start off", 1'b0, soft_start_charge);
    cyc(3);
    chk1("power ok", 1'b0, power_ok_n);
    chk1("board reset", 1'b1, board_reset_n);
    hold_rst = 1'b1;
    cyc(5);
    chk1("board reset host", 1'b0, board_reset_n);
    hold_rst = 1'b0;
    wait_tcur(psq_pkg::TCUR_IDLE, n);
    chk1("good length", 1'b1, n >= GD_C - 2 && n <= GD_C + 7);
    chk("normal gates", 4'hf, gate_on);
    chk1("no good fault", 1'b0, fault_good);
    on_in = 1'b0;
    cyc(5);
    chk("on fall gates", 4'h0, gate_on);
  endtask

  // power bad deglitch keeps switches on
  task automatic t_pbad();
    bring_up();
    power_bad = 4'h4;
    cyc(500);
    chk1("power ok in glitch", 1'b0, power_ok_n);
    chk1("power ok pulled", 1'b0, pok_drv_n);
    cyc(150);
    chk1("power ok bad", 1'b1, power_ok_n);
    chk1("board reset bad", 1'b0, board_reset_n);
    chk1("power ok released", 1'b1, pok_drv_n);
    chk1("board reset pulled", 1'b0, rst_drv_n);
    chk("gates kept", 4'hf, gate_on);
  endtask

  // undervoltage trip in normal mode, fault cleared by on falling
  task automatic t_uv();
    bring_up();
    supply_uv = 4'h2;
    cyc(6);
    chk("uv gates", 4'h0, gate_on);
    chk1("uv fault", 1'b1, fault_undervoltage);
    supply_uv = 4'h0;
    on_in = 1'b0;
    cyc(6);
    chk1("uv fault cleared", 1'b0, fault_undervoltage);
  endtask

  // good input loss with check on, then with check off
  task automatic t_good();
    bring_up();
    fail = 1'b1;
    cyc(700);
    chk("good filter", 4'hf, gate_on);
    cyc(150);
    chk("good loss gates", 4'h0, gate_on);
    chk1("good fault", 1'b1, fault_good);
    bring_up();
    write_ctrl(4'hf, 1'b0, 1'b1);
    fail = 1'b1;
    cyc(900);
    chk("good ignored", 4'hf, gate_on);
    restart(1'b1, psq_pkg::CFG_LOW, 4'h0);
    fail = 1'b1;
    wait_tcur(psq_pkg::TCUR_GOOD, n);
    wait_tcur(psq_pkg::TCUR_COOL, n);
    chk("timeout gates", 4'h0, gate_on);
    chk1("timeout fault", 1'b1, fault_good);
  endtask

  // current limit at start-up end, breaker trip in normal mode
  task automatic t_oc();
    restart(1'b1, psq_pkg::CFG_LOW, 4'h0);
    current_limit = 4'h1;
    wait_gate(4'hf, n);
    wait_tcur(psq_pkg::TCUR_COOL, n);
    chk("limit gates", 4'h0, gate_on);
    chk1("limit fault", 1'b1, fault_overcurrent);
    chk("not armed", 4'h0, breaker_armed);
    wait_tcur(psq_pkg::TCUR_IDLE, n);
    chk1("cool length", 1'b1, n >= CL_C + 3 && n <= CL_C + 7);
    bring_up();
    breaker_comparator = 4'h4;
    cyc(6);
    chk("breaker gates", 4'h0, gate_on);
    chk1("breaker fault", 1'b1, fault_overcurrent);
  endtask

  // sequenced turn-on and per-supply on bits
  task automatic t_seq();
    restart(1'b0, psq_pkg::CFG_LOW, 4'h0);
    write_ctrl(4'hf, 1'b1, 1'b0);
    wait_gate(4'h1, n);
    chk("seq first", 4'h1, gate_on);
    wait_gate(4'h3, n);
    chk("seq second", 4'h3, gate_on);
    chk1("seq spacing", 1'b1, n >= ST_C + 3 && n <= ST_C + 7);
    wait_gate(4'h7, n);
    chk("seq third", 4'h7, gate_on);
    wait_gate(4'hf, n);
    chk("seq last", 4'hf, gate_on);
    write_ctrl(4'hb, 1'b1, 1'b0);
    cyc(3);
    chk("single off", 4'hb, gate_on);
    chk("single bits", 4'hb, on_bits);
  endtask

  // -12V lockout and configuration pin
  task automatic t_cfg();
    restart(1'b1, psq_pkg::CFG_LOW, 4'h8);
    cyc(90);
    chk("lockout", 4'h0, gate_on);
    chk1("vee on", 1'b0, vee_checks_off);
    restart(1'b1, psq_pkg::CFG_OPEN, 4'h8);
    wait_gate(4'hf, n);
    chk("lockout off", 4'hf, gate_on);
    chk1("vee off", 1'b1, vee_checks_off);
    chk1("five levels open", 1'b0, five_at_three_levels);
    cfg_mode = psq_pkg::CFG_HIGH;
    cyc(5);
    chk1("five levels high", 1'b1, five_at_three_levels);
  endtask

  // card pulled and reseated with on held high
  task automatic t_remove();
    bring_up();
    seated = 1'b0;
    cyc(5);
    chk("removed gates", 4'h0, gate_on);
    seated = 1'b1;
    cyc(6);
    chk("reseat bits", 4'hf, on_bits);
  endtask

  initial begin
    t_simul();
    t_pbad();
    t_uv();
    t_good();
    t_oc();
    t_seq();
    t_cfg();
    t_remove();
    print_verdict();
  end
endmodule
`default_nettype wire
